// ===== design/crc_device_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "crc_link_cfg.svh"

// Overview of operation
// - Device checks CRC over all 32 command bits.
// - Bad command CRC: discard, send error response.
// - Check: seed, shift all bits, zero passes.
// - 8-bit polynomial x^8+x^5+x^3+x^2+x+1.
// - Seed FF, or F with select nibble.
// - Response CRC: seed, message, eight zeros.
// - Reserved commands answered with valid CRC.
// - 8-bit command field layout, fixed zeros.
// - Selectable 4-bit CRC on all messages.
// - Host places 4-bit register command fields.
// - Host zeros sensor command filler bits.
// - 4-bit polynomial x^4+1, seed is select.
// - 4-bit response CRC: four zeros appended.
module crc_device_end
  import crc_link_pkg::*;
#(
  parameter logic [15:0] RSVD_MASK = `RSVD_MASK_DEF // One bit per reserved command code.
)
(
  input  wire logic                 CLK_SYS_I,  // System clock, 20 MHz.
  input  wire logic                 RSTN_I,     // Synchronous reset, active low.
  crc_link_if.dev                   LINK,       // Link to the host end.
  input  wire logic                 CRC4_SEL_I, // Use the 4-bit CRC when high.
  input  wire crc_link_pkg::nib_t   SEED_SEL_I, // Seed select nibble.
  output logic                      CMD_VALID_O, // Good command pulse.
  output crc_link_pkg::nib_t        CMD_CODE_O,  // Command code.
  output crc_link_pkg::byte_t       CMD_INDEX_O, // Register index.
  output crc_link_pkg::byte_t       CMD_VALUE_O, // Register value.
  output logic                      CRC_ERR_O,   // Command CRC failure pulse.
  output logic                      RSVD_O,      // Reserved command pulse.
  output logic                      RSP_READY_O, // Response payload accepted.
  input  wire logic                 RSP_VALID_I, // Response payload valid.
  input  wire crc_link_pkg::frame_t RSP_WORD_I   // Response payload, CRC field ignored.
);
  import crc_link_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_USER  = 5'b00100,
    ST_GEN   = 5'b01000,
    ST_SEND  = 5'b10000
  } dev_state_t;

  dev_state_t state_q;
  dev_state_t state_d;
  frame_t     cmd_q;
  frame_t     rsp_q;
  crc_width_t width_q;
  byte_t      seed_q;
  logic       eng_start_q;
  frame_t     eng_word_q;
  logic       eng_busy;
  logic       eng_done;
  byte_t      eng_rem;
  logic       crc_bad;
  logic       is_rsvd;
  logic       fix_bad;

  // A remainder of zero after shifting the message and its CRC means a good command.
  assign crc_bad = (width_q == CRC_W4) ? (eng_rem[3:0] != `ZERO_NIB)
                                       : (eng_rem != `ZERO_BYTE);

  // Fixed bits that must be zero; a violation is treated like a corrupted frame.
  assign fix_bad = (cmd_q[`FIX_MSB:`FIX_LSB] != `ZERO_NIB) ||
                   ((width_q == CRC_W4) &&
                    (cmd_q[`PAD4_MSB:`PAD4_LSB] != `ZERO_NIB));

  // Reserved codes are looked up in the mask parameter.
  assign is_rsvd = RSVD_MASK[cmd_q[`CMD_MSB:`CMD_LSB]];

  // Handshakes toward both sides come straight from the state.
  assign LINK.cmd_ready = (state_q == ST_IDLE);
  assign LINK.rsp_valid = (state_q == ST_SEND);
  assign LINK.rsp_word  = rsp_q;
  assign RSP_READY_O    = (state_q == ST_USER);

  // The shared engine checks commands and then generates the response CRC.
  crc_serial u_crc (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .start_i (eng_start_q),
    .word_i  (eng_word_q),
    .width_i (width_q),
    .seed_i  (seed_q),
    .busy_o  (eng_busy),
    .done_o  (eng_done),
    .rem_o   (eng_rem)
  );

  // Next-state decode.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (LINK.cmd_valid) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (eng_done) begin
          if (crc_bad || fix_bad || is_rsvd) begin
            state_d = ST_GEN;
          end else begin
            state_d = ST_USER;
          end
        end
      end
      ST_USER: begin
        if (RSP_VALID_I) begin
          state_d = ST_GEN;
        end
      end
      ST_GEN: begin
        if (eng_done) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (LINK.rsp_ready) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Width and seed are frozen per exchange, so a mid-frame change cannot split a message.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      width_q <= CRC_W8;
      seed_q  <= `SEED_ALL_ONES;
      cmd_q   <= `ZERO_FRAME;
    end else if ((state_q == ST_IDLE) && LINK.cmd_valid) begin
      width_q <= CRC4_SEL_I ? CRC_W4 : CRC_W8;
      seed_q  <= seed_of(CRC4_SEL_I ? CRC_W4 : CRC_W8, SEED_SEL_I);
      cmd_q   <= LINK.cmd_word;
    end
  end

  // Engine launches: the whole command with its CRC, then the response with a cleared CRC field.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      eng_start_q <= 1'b0;
      eng_word_q  <= `ZERO_FRAME;
    end else begin
      eng_start_q <= 1'b0;
      if ((state_q == ST_IDLE) && LINK.cmd_valid) begin
        eng_start_q <= 1'b1;
        eng_word_q  <= LINK.cmd_word;
      end else if ((state_q == ST_CHECK) && (state_d == ST_GEN)) begin
        eng_start_q <= 1'b1;
        if (crc_bad || fix_bad) begin
          eng_word_q <= error_frame(width_q);
        end else begin
          eng_word_q <= `ZERO_FRAME;
        end
      end else if ((state_q == ST_USER) && RSP_VALID_I) begin
        eng_start_q <= 1'b1;
        eng_word_q  <= clear_crc(RSP_WORD_I, width_q);
      end
    end
  end

  // Response frame: payload latched at launch, CRC field filled when the engine is done.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      rsp_q <= `ZERO_FRAME;
    end else if (eng_start_q && (state_q == ST_GEN)) begin
      rsp_q <= eng_word_q;
    end else if ((state_q == ST_GEN) && eng_done) begin
      rsp_q <= put_crc(rsp_q, width_q, eng_rem);
    end
  end

  // User command outputs; a failed or reserved command never reaches the user.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      CMD_VALID_O <= 1'b0;
      CMD_CODE_O  <= `ZERO_NIB;
      CMD_INDEX_O <= `ZERO_BYTE;
      CMD_VALUE_O <= `ZERO_BYTE;
    end else begin
      CMD_VALID_O <= (state_q == ST_CHECK) && (state_d == ST_USER);
      if ((state_q == ST_CHECK) && (state_d == ST_USER)) begin
        CMD_CODE_O  <= cmd_q[`CMD_MSB:`CMD_LSB];
        CMD_INDEX_O <= cmd_q[`IDX_MSB:`IDX_LSB];
        CMD_VALUE_O <= cmd_q[`VAL_MSB:`VAL_LSB];
      end
    end
  end

  // Event pulses for the surrounding logic.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      CRC_ERR_O <= 1'b0;
      RSVD_O    <= 1'b0;
    end else begin
      CRC_ERR_O <= (state_q == ST_CHECK) && eng_done && (crc_bad || fix_bad);
      RSVD_O    <= (state_q == ST_CHECK) && eng_done && !crc_bad && !fix_bad
                   && is_rsvd;
    end
  end

  // Error response body: zero command, error status, everything else zero.
  function automatic frame_t error_frame(input crc_width_t w);
    frame_t f;
    f = `ZERO_FRAME;
    f[`CMD_MSB:`CMD_LSB]   = `ERR_CMD;
    f[`STAT_MSB:`STAT_LSB] = `ERR_STATUS;
    return clear_crc(f, w);
  endfunction

  // The engine is never restarted while shifting; the busy flag is left unused here.
  logic unused_busy;
  assign unused_busy = eng_busy;
endmodule

`default_nettype wire

// ===== design/crc_link_cfg.svh
`ifndef CRC_LINK_CFG_SVH
`define CRC_LINK_CFG_SVH

// Frame geometry.
`define FRAME_W        32
`define BIT_CNT_W      5
`define BIT_CNT_LAST   5'h1F

// Polynomial taps below the leading term (x^8 + x^5 + x^3 + x^2 + x + 1, x^4 + 1).
`define CRC8_POLY      8'h2F
`define CRC4_POLY      4'h1

// Seeds.
`define SEED_ALL_ONES  8'hFF
`define SEED_UPPER     4'hF
`define SEED_SEL_ZERO  4'h0

// Command and response field positions.
`define CMD_MSB        31
`define CMD_LSB        28
`define FIX_MSB        27
`define FIX_LSB        24
`define IDX_MSB        23
`define IDX_LSB        16
`define VAL_MSB        15
`define VAL_LSB        8
`define CRC8_MSB       7
`define CRC8_LSB       0
`define PAD4_MSB       7
`define PAD4_LSB       4
`define CRC4_MSB       3
`define CRC4_LSB       0
`define STAT_MSB       27
`define STAT_LSB       26

// Field values.
`define ERR_STATUS     2'h3
`define ERR_CMD        4'h0
`define ZERO_NIB       4'h0
`define ZERO_BYTE      8'h00
`define ZERO_FRAME     32'h0000_0000
`define RSVD_MASK_DEF  16'h0000

`endif

// ===== design/crc_link_pkg.sv
package crc_link_pkg;
  `include "crc_link_cfg.svh"

  typedef logic [`FRAME_W-1:0] frame_t;
  typedef logic [3:0]          nib_t;
  typedef logic [7:0]          byte_t;

  // Selected CRC width for one message.
  typedef enum logic {
    CRC_W8 = 1'b0,
    CRC_W4 = 1'b1
  } crc_width_t;

  // Seed preset into the shift register, into the low nibble only in 4-bit mode.
  function automatic byte_t seed_of(input crc_width_t width, input nib_t sel);
    byte_t s;
    s = `SEED_ALL_ONES;
    if (width == CRC_W4) begin
      s = {`ZERO_NIB, sel};
    end else if (sel != `SEED_SEL_ZERO) begin
      s = {`SEED_UPPER, sel};
    end
    return s;
  endfunction

  // Clears the CRC field so that shifting the frame appends the zero bits.
  function automatic frame_t clear_crc(input frame_t f, input crc_width_t width);
    frame_t r;
    r = f;
    if (width == CRC_W4) begin
      r[`CRC4_MSB:`CRC4_LSB] = `ZERO_NIB;
    end else begin
      r[`CRC8_MSB:`CRC8_LSB] = `ZERO_BYTE;
    end
    return r;
  endfunction

  // Places a remainder into the CRC field of the frame.
  function automatic frame_t put_crc(input frame_t f, input crc_width_t width, input byte_t c);
    frame_t r;
    r = f;
    if (width == CRC_W4) begin
      r[`CRC4_MSB:`CRC4_LSB] = c[3:0];
    end else begin
      r[`CRC8_MSB:`CRC8_LSB] = c;
    end
    return r;
  endfunction
endpackage

// ===== design/crc_link_if.sv
`timescale 1ns/100ps
`default_nettype none

// Word-level link between the host and the device: one command, one response.
interface crc_link_if;
  import crc_link_pkg::*;

  logic   cmd_valid;
  logic   cmd_ready;
  frame_t cmd_word;
  logic   rsp_valid;
  logic   rsp_ready;
  frame_t rsp_word;

  modport host (
    output cmd_valid, cmd_word, rsp_ready,
    input  cmd_ready, rsp_valid, rsp_word
  );

  modport dev (
    input  cmd_valid, cmd_word, rsp_ready,
    output cmd_ready, rsp_valid, rsp_word
  );
endinterface

`default_nettype wire

// ===== design/crc_serial.sv
`timescale 1ns/100ps
`default_nettype none
`include "crc_link_cfg.svh"

// Serial CRC engine: presets the seed, then shifts all 32 bits of a word, MSB first.
module crc_serial
  import crc_link_pkg::*;
(
  input  wire logic                    clk_i,   // System clock.
  input  wire logic                    rstn_i,  // Synchronous reset, active low.
  input  wire logic                    start_i, // Start pulse, word and settings sampled.
  input  wire crc_link_pkg::frame_t    word_i,  // Word to shift.
  input  wire crc_link_pkg::crc_width_t width_i, // CRC width.
  input  wire crc_link_pkg::byte_t     seed_i,  // Seed for the shift register.
  output logic                         busy_o,  // Shifting in progress.
  output logic                         done_o,  // One-cycle pulse, remainder valid.
  output crc_link_pkg::byte_t          rem_o    // Remainder, low nibble in 4-bit mode.
);
  import crc_link_pkg::*;

  frame_t                data_q;
  byte_t                 reg_q;
  crc_width_t            width_q;
  logic [`BIT_CNT_W-1:0] cnt_q;

  // One shift of the register with the next message bit entering at the bottom.
  function automatic byte_t crc_step(input byte_t r, input logic b, input crc_width_t w);
    byte_t n;
    if (w == CRC_W4) begin
      n = {`ZERO_NIB, r[2:0], b};
      if (r[3]) begin
        n[3:0] = n[3:0] ^ `CRC4_POLY;
      end
    end else begin
      n = {r[6:0], b};
      if (r[7]) begin
        n = n ^ `CRC8_POLY;
      end
    end
    return n;
  endfunction

  // Shift path; a start while busy restarts the word.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_q  <= `ZERO_FRAME;
      reg_q   <= `ZERO_BYTE;
      width_q <= CRC_W8;
      cnt_q   <= '0;
      busy_o  <= 1'b0;
    end else if (start_i) begin
      data_q  <= word_i;
      reg_q   <= seed_i;
      width_q <= width_i;
      cnt_q   <= '0;
      busy_o  <= 1'b1;
    end else if (busy_o) begin
      reg_q  <= crc_step(reg_q, data_q[`FRAME_W-1], width_q);
      data_q <= {data_q[`FRAME_W-2:0], 1'b0};
      cnt_q  <= cnt_q + 1'b1;
      if (cnt_q == `BIT_CNT_LAST) begin
        busy_o <= 1'b0;
      end
    end
  end

  // Completion pulse follows the last shifted bit.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && !start_i && (cnt_q == `BIT_CNT_LAST);
    end
  end

  assign rem_o = reg_q;
endmodule

`default_nettype wire

// ===== design/crc_host_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "crc_link_cfg.svh"

// Host end: builds commands, appends their CRC and checks each response CRC.
module crc_host_end
  import crc_link_pkg::*;
(
  input  wire logic                CLK_SYS_I,    // System clock, 20 MHz.
  input  wire logic                RSTN_I,       // Synchronous reset, active low.
  crc_link_if.host                 LINK,         // Link to the device end.
  input  wire logic                CRC4_SEL_I,   // Use the 4-bit CRC when high.
  input  wire crc_link_pkg::nib_t  SEED_SEL_I,   // Seed select nibble.
  input  wire logic                REQ_VALID_I,  // Request valid.
  output logic                     REQ_READY_O,  // Request accepted.
  input  wire logic                REQ_SENSOR_I, // Sensor data command, fields forced zero.
  input  wire crc_link_pkg::nib_t  REQ_CODE_I,   // Command code.
  input  wire crc_link_pkg::byte_t REQ_INDEX_I,  // Register index.
  input  wire crc_link_pkg::byte_t REQ_VALUE_I,  // Register value.
  output logic                     ANS_VALID_O,  // Response pulse.
  output crc_link_pkg::frame_t     ANS_WORD_O,   // Response word as received.
  output logic                     ANS_CRC_OK_O  // Response CRC checked good.
);
  import crc_link_pkg::*;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_GEN   = 5'b00010,
    HS_SEND  = 5'b00100,
    HS_WAIT  = 5'b01000,
    HS_CHECK = 5'b10000
  } host_state_t;

  host_state_t state_q;
  frame_t      cmd_q;
  crc_width_t  width_q;
  byte_t       seed_q;
  logic        eng_start_q;
  frame_t      eng_word_q;
  logic        eng_done;
  byte_t       eng_rem;
  frame_t      frame;

  // Command layout; sensor commands carry only the code.
  always_comb begin
    frame = `ZERO_FRAME;
    frame[`CMD_MSB:`CMD_LSB] = REQ_CODE_I;
    if (!REQ_SENSOR_I) begin
      frame[`IDX_MSB:`IDX_LSB] = REQ_INDEX_I;
      frame[`VAL_MSB:`VAL_LSB] = REQ_VALUE_I;
    end
  end

  assign REQ_READY_O    = (state_q == HS_IDLE);
  assign LINK.cmd_valid = (state_q == HS_SEND);
  assign LINK.cmd_word  = cmd_q;
  assign LINK.rsp_ready = (state_q == HS_WAIT);

  crc_serial u_crc (
    .clk_i   (CLK_SYS_I),
    .rstn_i  (RSTN_I),
    .start_i (eng_start_q),
    .word_i  (eng_word_q),
    .width_i (width_q),
    .seed_i  (seed_q),
    .busy_o  (),
    .done_o  (eng_done),
    .rem_o   (eng_rem)
  );

  // Sequencer, command register and engine launches.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      state_q     <= HS_IDLE;
      cmd_q       <= `ZERO_FRAME;
      width_q     <= CRC_W8;
      seed_q      <= `SEED_ALL_ONES;
      eng_start_q <= 1'b0;
      eng_word_q  <= `ZERO_FRAME;
    end else begin
      eng_start_q <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (REQ_VALID_I) begin
            width_q     <= CRC4_SEL_I ? CRC_W4 : CRC_W8;
            seed_q      <= seed_of(CRC4_SEL_I ? CRC_W4 : CRC_W8, SEED_SEL_I);
            cmd_q       <= frame;
            eng_word_q  <= frame;
            eng_start_q <= 1'b1;
            state_q     <= HS_GEN;
          end
        end
        HS_GEN: begin
          if (eng_done) begin
            cmd_q   <= put_crc(cmd_q, width_q, eng_rem);
            state_q <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (LINK.cmd_ready) begin
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (LINK.rsp_valid) begin
            eng_word_q  <= LINK.rsp_word;
            eng_start_q <= 1'b1;
            state_q     <= HS_CHECK;
          end
        end
        HS_CHECK: begin
          if (eng_done) begin
            state_q <= HS_IDLE;
          end
        end
        default: begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  // Answer outputs.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      ANS_VALID_O  <= 1'b0;
      ANS_WORD_O   <= `ZERO_FRAME;
      ANS_CRC_OK_O <= 1'b0;
    end else begin
      ANS_VALID_O <= (state_q == HS_CHECK) && eng_done;
      if ((state_q == HS_CHECK) && eng_done) begin
        ANS_WORD_O   <= eng_word_q;
        ANS_CRC_OK_O <= (width_q == CRC_W4) ? (eng_rem[3:0] == `ZERO_NIB)
                                            : (eng_rem == `ZERO_BYTE);
      end
    end
  end
endmodule

`default_nettype wire

// ===== test/crc_ref.svh
// Included into each module that needs it, so it carries no guard of its own.
// Bit-serial remainder, MSB first; zero over a whole frame means its CRC is good.
function automatic logic [7:0] crc_run(input logic w4, input logic [3:0] sel,
                                       input logic [31:0] f);
  logic [7:0] r;
  logic       fb;
  r = w4 ? {4'h0, sel} : ((sel == 4'h0) ? 8'hFF : {4'hF, sel});
  for (int i = 31; i >= 0; i--) begin
    fb = w4 ? r[3] : r[7];
    r = {r[6:0], f[i]};
    if (w4) r = {4'h0, r[3:1], r[0] ^ fb};
    else if (fb) r = r ^ 8'h2F;
  end
  return r;
endfunction

// Clears the CRC field, which appends the zero bits, and inserts the remainder.
function automatic logic [31:0] with_crc(input logic w4, input logic [3:0] sel,
                                         input logic [31:0] f);
  logic [31:0] z;
  logic [7:0]  c;
  z = w4 ? {f[31:4], 4'h0} : {f[31:8], 8'h00};
  c = crc_run(w4, sel, z);
  return w4 ? {z[31:4], c[3:0]} : {z[31:8], c};
endfunction

// ===== test/crc_link_props.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the word link between the two ends.
module crc_link_props
  import crc_link_pkg::*;
(
  input  wire logic                 CLK_SYS_I,  // System clock.
  input  wire logic                 RSTN_I,     // Synchronous reset, active low.
  input  wire logic                 CRC4_SEL_I, // 4-bit CRC select.
  input  wire crc_link_pkg::nib_t   SEED_SEL_I, // Seed select.
  input  wire logic                 cmd_valid,  // Command offered.
  input  wire logic                 cmd_ready,  // Command accepted.
  input  wire crc_link_pkg::frame_t cmd_word,   // Command frame.
  input  wire logic                 rsp_valid,  // Response offered.
  input  wire logic                 rsp_ready,  // Response accepted.
  input  wire crc_link_pkg::frame_t rsp_word    // Response frame.
);
  `include "crc_ref.svh"

  // Selects only change between exchanges, so the live values apply to the words.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  property p_cmd_fixed;
    cmd_valid |-> cmd_word[27:24] == 4'h0;
  endproperty
  a_cmd_fixed: assert property (p_cmd_fixed) else $error("Command fixed bits not zero");
  property p_cmd_pad4;
    cmd_valid && CRC4_SEL_I |-> cmd_word[7:4] == 4'h0;
  endproperty
  a_cmd_pad4: assert property (p_cmd_pad4) else $error("Command pad bits not zero");
  property p_cmd_crc;
    cmd_valid |-> crc_run(CRC4_SEL_I, SEED_SEL_I, cmd_word) == 8'h00;
  endproperty
  a_cmd_crc: assert property (p_cmd_crc) else $error("Command CRC does not check");
  property p_rsp_crc;
    rsp_valid |-> crc_run(CRC4_SEL_I, SEED_SEL_I, rsp_word) == 8'h00;
  endproperty
  a_rsp_crc: assert property (p_rsp_crc) else $error("Response CRC does not check");
  property p_rsp_quiet;
    cmd_valid && cmd_ready |=> !rsp_valid [*8];
  endproperty
  a_rsp_quiet: assert property (p_rsp_quiet) else $error("Response before check ended");
  property p_rsp_bound;
    cmd_valid && cmd_ready |-> ##[60:300] rsp_valid;
  endproperty
  a_rsp_bound: assert property (p_rsp_bound) else $error("No response to command");
  property p_busy_s;
    rsp_valid |-> !cmd_ready;
  endproperty
  a_busy_s: assert property (p_busy_s) else $error("Command taken while answering");
  property p_cmd_once;
    cmd_valid && cmd_ready |=> !cmd_valid && !cmd_ready;
  endproperty
  a_cmd_once: assert property (p_cmd_once) else $error("Command word sent twice");
  property p_rsp_once;
    rsp_valid && rsp_ready |=> !rsp_valid;
  endproperty
  a_rsp_once: assert property (p_rsp_once) else $error("Response word sent twice");
endmodule

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import crc_link_pkg::*;
  `include "crc_ref.svh"

  localparam logic [15:0] RSVD = 16'h0404; // Codes 2 and 10 are reserved.
  logic   clk_sys, rstn, crc4_sel, req_valid, req_sensor, rsp_valid_u;
  nib_t   seed_sel, req_code, cmd_code;
  byte_t  req_index, req_value, cmd_index, cmd_value;
  frame_t rsp_word_u, ans_word;
  logic   req_ready, ans_valid, ans_ok, cmd_ok, crc_err, rsvd, rsp_ready_u;
  logic   cmd_ok2, crc_err2, rsvd2;
  int     miscompares, compares;
  logic [31:0] kat [7] = '{32'h8022C1BD, 32'h401FC157, 32'hC0220066, 32'h601FC1B8,
                           32'h40FF5AE5, 32'hC03E0013, 32'h60FF5A0A};

  crc_link_if lk();
  crc_link_if lk2();
  crc_host_end crc_host_end_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .LINK(lk.host),
    .CRC4_SEL_I(crc4_sel), .SEED_SEL_I(seed_sel), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_SENSOR_I(req_sensor), .REQ_CODE_I(req_code),
    .REQ_INDEX_I(req_index), .REQ_VALUE_I(req_value), .ANS_VALID_O(ans_valid),
    .ANS_WORD_O(ans_word), .ANS_CRC_OK_O(ans_ok));
  crc_device_end #(.RSVD_MASK(RSVD)) crc_device_end_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn),
    .LINK(lk.dev), .CRC4_SEL_I(crc4_sel), .SEED_SEL_I(seed_sel), .CMD_VALID_O(cmd_ok),
    .CMD_CODE_O(cmd_code), .CMD_INDEX_O(cmd_index), .CMD_VALUE_O(cmd_value),
    .CRC_ERR_O(crc_err), .RSVD_O(rsvd), .RSP_READY_O(rsp_ready_u),
    .RSP_VALID_I(rsp_valid_u), .RSP_WORD_I(rsp_word_u));
  // The second device faces the bench, which breaks the host's rules on purpose.
  crc_device_end #(.RSVD_MASK(RSVD)) crc_device_end_2_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn),
    .LINK(lk2.dev), .CRC4_SEL_I(crc4_sel), .SEED_SEL_I(seed_sel), .CMD_VALID_O(cmd_ok2),
    .CMD_CODE_O(), .CMD_INDEX_O(), .CMD_VALUE_O(), .CRC_ERR_O(crc_err2), .RSVD_O(rsvd2),
    .RSP_READY_O(), .RSP_VALID_I(1'b1), .RSP_WORD_I(rsp_word_u));
  crc_link_props crc_link_props_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn), .CRC4_SEL_I(crc4_sel),
    .SEED_SEL_I(seed_sel), .cmd_valid(lk.cmd_valid), .cmd_ready(lk.cmd_ready),
    .cmd_word(lk.cmd_word), .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
    .rsp_word(lk.rsp_word));

  // Free-running 20 MHz clock.
  always #25 clk_sys = ~clk_sys;

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp_w(input string nm, input frame_t exp, input frame_t got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmp_b(input string nm, input logic exp, input logic got);
    cmp_w(nm, {31'h0, exp}, {31'h0, got});
  endtask

  // Level or pulse condition that a wait looks for; all are settled at a falling edge.
  function automatic logic sig(input int k);
    case (k)
      0: return req_ready;
      1: return lk.cmd_valid & lk.cmd_ready;
      2: return cmd_ok | rsvd | crc_err;
      3: return rsp_ready_u;
      4: return ans_valid;
      5: return lk2.cmd_ready;
      6: return cmd_ok2 | crc_err2 | rsvd2;
      default: return lk2.rsp_valid;
    endcase
  endfunction

  task automatic wait_for(input int k, input string nm);
    for (int n = 0; n < 400; n++) begin
      if (sig(k) === 1'b1) return;
      @(negedge clk_sys);
    end
    miscompares++;
    $display("Error %s expected 1 seen timeout", nm);
    wrap_up();
  endtask

  // One full exchange through both ends; selects are held until the next one.
  task automatic xfer(input logic w4, input nib_t sel, input logic sen, input nib_t code,
                      input byte_t idx, input byte_t val, input frame_t pay);
    frame_t c;
    frame_t r;
    logic   rs;
    crc4_sel = w4;
    seed_sel = sel;
    req_sensor = sen;
    req_code = code;
    req_index = idx;
    req_value = val;
    req_valid = 1'b1;
    wait_for(0, "req_ready");
    @(negedge clk_sys);
    req_valid = 1'b0;
    c = with_crc(w4, sel, {code, 4'h0, sen ? 16'h0000 : {idx, val}, 8'h00});
    wait_for(1, "cmd_accept");
    cmp_w("cmd_word", c, lk.cmd_word);
    @(negedge clk_sys);
    wait_for(2, "dev_pulse");
    rs = RSVD[code];
    cmp_b("crc_err", 1'b0, crc_err);
    cmp_b("rsvd", rs, rsvd);
    cmp_b("cmd_valid", !rs, cmd_ok);
    if (!rs) begin
      cmp_w("cmd_fields", {12'h0, c[31:28], c[23:8]}, {12'h0, cmd_code, cmd_index, cmd_value});
      rsp_word_u = pay;
      rsp_valid_u = 1'b1;
      wait_for(3, "rsp_ready");
      @(negedge clk_sys);
      rsp_valid_u = 1'b0;
    end
    r = with_crc(w4, sel, rs ? 32'h0 : pay);
    wait_for(4, "answer");
    cmp_w("ans_word", r, ans_word);
    cmp_b("ans_ok", 1'b1, ans_ok);
    @(negedge clk_sys);
  endtask

  // Offers a raw frame to the second device and checks verdict and error reply.
  task automatic inject(input logic w4, input nib_t sel, input frame_t f, input logic ok);
    crc4_sel = w4;
    seed_sel = sel;
    lk2.cmd_word = f;
    lk2.cmd_valid = 1'b1;
    wait_for(5, "cmd_ready2");
    @(negedge clk_sys);
    lk2.cmd_valid = 1'b0;
    wait_for(6, "dev2_pulse");
    cmp_b("crc_err2", !ok, crc_err2);
    cmp_b("cmd_valid2", ok, cmd_ok2);
    wait_for(7, "rsp_valid2");
    if (!ok) cmp_w("err_rsp", with_crc(w4, sel, 32'h0C000000), lk2.rsp_word);
    lk2.rsp_ready = 1'b1;
    @(negedge clk_sys);
    lk2.rsp_ready = 1'b0;
  endtask

  // Reset, the table of known frames, a sweep of every select in both widths, then faults.
  initial begin
    frame_t f;
    nib_t   s;
    {clk_sys, rstn, crc4_sel, req_valid, req_sensor, rsp_valid_u} = 6'h00;
    {seed_sel, req_code, req_index, req_value, rsp_word_u} = 56'h0;
    {lk2.cmd_valid, lk2.rsp_ready, lk2.cmd_word} = 34'h0;
    {miscompares, compares} = 64'h0;
    void'($urandom(32'hD4B25FB3));
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    foreach (kat[i]) inject(1'b0, 4'h0, kat[i], 1'b1);
    for (int i = 0; i < 32; i++) begin
      xfer(i[0], i[4:1], $urandom % 4 == 0, 4'(i * 7), 8'($urandom), 8'($urandom),
           $urandom);
    end
    for (int i = 0; i < 8; i++) begin
      // Code bit 1 is cleared, which keeps the reserved codes out of the good frames.
      s = 4'($urandom);
      f = with_crc(i[0], s, $urandom & 32'hD0FFFF00);
      inject(i[0], s, f, 1'b1);
      inject(i[0], s, f ^ (32'h1 << (i % 4)), 1'b0);
      inject(i[0], s, f ^ 32'h02000000, 1'b0);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
